// file: src/cmpirq_chan.sv
// Purpose: one channel's latch, internal enable and interrupt flag
// Assumes: result is already synchronised to clk_sys
// Notes: a hardware set of the flag wins over a software clear
`timescale 1ns/10ps
module cmpirq_chan (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // live result and control
  input wire logic result,
  input wire logic chan_on,
  input wire logic irq_on,
  // bus strobes
  input wire logic data_read,
  input wire logic clear_req,
  // state
  output logic flag,
  output logic armed,
  output logic int_en,
  output logic latch,
  output logic irq_event
);

  logic flag_ff;
  logic armed_ff;
  logic int_en_ff;
  logic latch_ff;
  logic nxt_flag;
  logic nxt_armed;
  logic nxt_int_en;
  logic nxt_latch;

  // mismatch is masked while the result is being read
  assign irq_event = int_en_ff & (result ^ latch_ff) & ~data_read; // [R11] [R12]
  // any read of the data register refreshes the latch
  assign nxt_latch = data_read ? result : latch_ff; // [R10] [R13]
  // arming needs both enables; dropping either disarms
  assign nxt_int_en = (chan_on & irq_on) & (data_read | int_en_ff); // [R10] [R14]
  // remember whether the last read saw the flag set
  assign nxt_armed = data_read ? flag_ff : (armed_ff & ~clear_req); // [R3] [R5]
  // set beats clear; a clear without a prior read of 1 is ignored
  assign nxt_flag = irq_event | (flag_ff & ~(clear_req & armed_ff)); // [R2] [R4] [R3] [R5]

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flag_ff <= 1'b0;
      armed_ff <= 1'b0;
      int_en_ff <= 1'b0;
      latch_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      armed_ff <= nxt_armed;
      int_en_ff <= nxt_int_en;
      latch_ff <= nxt_latch;
    end
  end

  assign flag = flag_ff;
  assign armed = armed_ff;
  assign int_en = int_en_ff;
  assign latch = latch_ff;

endmodule

// file: src/cmpirq_pkg.sv
// Purpose: constants and types shared by the comparator result block
// Assumes: 32-bit AXI4-Lite access, one aligned word per register
// Notes: registers are 8 bits wide in the low byte, upper bits read zero
//
// What this block does
// R1: data register bits 7:6 and 3:2 read zero, writes ignored.
// R2: bit 5 is channel 1 flag, reset 0, set on channel 1 event.
// R3: channel 1 flag clears on a 0 write only after reading it as 1.
// R4: bit 4 is channel 0 flag, reset 0, set on channel 0 event.
// R5: channel 0 flag clears on a 0 write only after reading it as 1.
// R6: writing 1 to a flag does nothing.
// R7: bit 1 shows channel 1 comparator output, 1 when input exceeds reference.
// R8: bit 0 shows channel 0 comparator output, 1 when input exceeds reference.
// R9: result bits follow the live comparison right from reset.
// R10: reading result with channel and irq enabled latches it and arms internal enable.
// R11: armed channel sets its flag when live result differs from latch.
// R12: no event for a channel in the cycle its result is read.
// R13: every data register read refreshes the latches.
// R14: clearing irq enable drops the internal interrupt enable.
// R15: software sets reference, hysteresis, level, enables, then waits before reading.
// R16: software reads, sets irq enable, reads again, back to back.
// R17: software clears channel enables before stopping the module clock.
// R18: enabled comparator keeps running and flagging in low-power modes.
// R19: an enabled channel's input pin is dedicated to the comparator.
// R20: per-channel control: bit 7 on, 6 irq on, 5 external ref, 4 hysteresis.
// R21: software never selects external reference together with hysteresis.
// R22: comparator outputs pass a two-flop synchroniser before any use.

package cmpirq_pkg;

  localparam int NCHAN = 2;

  // register byte offsets
  localparam logic [1:0][7:0] CTRL_OFS = {8'h04, 8'h00};
  localparam logic [7:0] DATA_OFS = 8'h08;

  // field positions
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_IRQ_BIT = 6;
  localparam int FLAG_LSB = 4;
  localparam int RESULT_LSB = 0;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] BIT2_RST = 2'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [3:0] STRB_RST = 4'h0;
  localparam logic [1:0] SETTLE_MAX = 2'h3;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one channel's control register, msb first
  typedef struct packed {
    logic on;
    logic irq_on;
    logic ext_ref;
    logic hyst;
    logic [3:0] ref_level;
  } cmpirq_ctrl_type;

endpackage

// file: src/cmpirq_sync.sv
// Purpose: two-flop synchroniser for the comparator outputs
// Assumes: inputs change with no relation to clk_sys
// Notes: first stage is read by the second stage only
`timescale 1ns/10ps
module cmpirq_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // raw and synchronised levels
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);

  logic [1:0] meta_ff;
  logic [1:0] sync_ff;

  // two stages, reset to a defined level
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_ff <= cmpirq_pkg::BIT2_RST;
      sync_ff <= cmpirq_pkg::BIT2_RST;
    end else begin
      meta_ff <= async_in; // [R22]
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// file: src/cmpirq_top.sv
// Purpose: comparator result and interrupt flags behind an AXI4-Lite slave
// Assumes: comparator outputs are asynchronous levels from the analog side
// Notes: one write and one read in flight; unmapped addresses answer SLVERR
`timescale 1ns/10ps
module cmpirq_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // analog comparators
  input wire logic [1:0] cmp_out_async,
  output cmpirq_pkg::cmpirq_ctrl_type [1:0] chan_control,
  output logic [1:0] pin_dedicated,
  // interrupt flags towards the cpu
  output logic [1:0] chan_irq_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  cmpirq_pkg::cmpirq_ctrl_type [1:0] ctrl_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic wr_fire;
  logic wr_is_data;
  logic wr_hit;
  logic [1:0] wr_is_ctrl;
  logic [1:0] wr_ctrl;
  logic rd_is_data;
  logic rd_hit;
  logic [1:0] rd_is_ctrl;
  logic data_read;
  logic [1:0] clear_req;
  logic [1:0] result_sync;
  logic [1:0] flag;
  logic [1:0] armed;
  logic [1:0] int_en;
  logic [1:0] latch;
  logic [1:0] chan_event;
  logic [7:0] data_byte;
  logic [31:0] rd_word;
  logic [1:0] settle_ff;
  logic rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // comparator outputs cross into clk_sys before anything looks at them

  cmpirq_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(cmp_out_async), // [R22]
    .sync_out(result_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write path: address and data taken in either order, then one write

  assign aw_hs = s_axi_awvalid & awready_ff;
  assign w_hs = s_axi_wvalid & wready_ff;
  assign b_hs = bvalid_ff & s_axi_bready;
  // both halves held and no response pending
  assign wr_fire = ~awready_ff & ~wready_ff & ~bvalid_ff;
  assign wr_is_data = awaddr_ff == cmpirq_pkg::DATA_OFS;
  assign wr_is_ctrl[0] = awaddr_ff == cmpirq_pkg::CTRL_OFS[0];
  assign wr_is_ctrl[1] = awaddr_ff == cmpirq_pkg::CTRL_OFS[1];
  assign wr_hit = wr_is_data | (|wr_is_ctrl);
  // only the low byte lane carries register bits
  assign wr_ctrl = {2{wr_fire & wstrb_ff[0]}} & wr_is_ctrl;

  // handshake flags; readies reopen only after the response is taken
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= cmpirq_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awready_ff <= 1'b0;
      end else if (b_hs) begin
        awready_ff <= 1'b1;
      end
      if (w_hs) begin
        wready_ff <= 1'b0;
      end else if (b_hs) begin
        wready_ff <= 1'b1;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? cmpirq_pkg::RESP_OKAY : cmpirq_pkg::RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // payload holding registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      awaddr_ff <= cmpirq_pkg::ADDR_RST;
      wdata_ff <= cmpirq_pkg::WORD_RST;
      wstrb_ff <= cmpirq_pkg::STRB_RST;
    end else begin
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel control registers and channel logic

  for (genvar i = 0; i < cmpirq_pkg::NCHAN; i++) begin : g_chan
    // a zero in a flag position asks for a clear; a one is ignored
    assign clear_req[i] = wr_fire & wstrb_ff[0] & wr_is_data &
                          ~wdata_ff[cmpirq_pkg::FLAG_LSB + i]; // [R6]

    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        ctrl_ff[i] <= cmpirq_pkg::cmpirq_ctrl_type'(cmpirq_pkg::CTRL_RST); // [R20]
      end else if (wr_ctrl[i]) begin
        ctrl_ff[i] <= cmpirq_pkg::cmpirq_ctrl_type'(wdata_ff[7:0]); // [R20]
      end
    end

    // no low-power input exists, so standby never stalls a channel [R18]
    cmpirq_chan u_chan (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .result(result_sync[i]),
      .chan_on(ctrl_ff[i].on),
      .irq_on(ctrl_ff[i].irq_on),
      .data_read(data_read),
      .clear_req(clear_req[i]),
      .flag(flag[i]),
      .armed(armed[i]),
      .int_en(int_en[i]),
      .latch(latch[i]),
      .irq_event(chan_event[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: answer one cycle after the address is taken

  assign ar_hs = s_axi_arvalid & arready_ff;
  assign r_hs = rvalid_ff & s_axi_rready;
  assign rd_is_data = s_axi_araddr == cmpirq_pkg::DATA_OFS;
  assign rd_is_ctrl[0] = s_axi_araddr == cmpirq_pkg::CTRL_OFS[0];
  assign rd_is_ctrl[1] = s_axi_araddr == cmpirq_pkg::CTRL_OFS[1];
  assign rd_hit = rd_is_data | (|rd_is_ctrl);
  // the read strobe for the latches is the address handshake itself
  assign data_read = ar_hs & rd_is_data; // [R13]
  // reserved pairs are tied to zero here
  assign data_byte = {2'h0, flag, 2'h0, result_sync}; // [R1] [R7] [R8] [R9]
  assign rd_word = rd_is_data ? {24'h00_0000, data_byte} :
                   rd_is_ctrl[1] ? {24'h00_0000, ctrl_ff[1]} :
                   rd_is_ctrl[0] ? {24'h00_0000, ctrl_ff[0]} :
                   cmpirq_pkg::WORD_RST;

  // data is captured at the handshake, the same edge the latches see
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= cmpirq_pkg::WORD_RST;
      rresp_ff <= cmpirq_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? cmpirq_pkg::RESP_OKAY : cmpirq_pkg::RESP_SLVERR;
    end else if (r_hs) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign chan_control = ctrl_ff;
  // an enabled channel claims its pin for the analog input
  assign pin_dedicated = {ctrl_ff[1].on, ctrl_ff[0].on}; // [R19]
  assign chan_irq_flag = flag;

  ////////////////////////////////////////////////////////////////////////////
  // checks; helper state below is read by assertions only

  // cycles since reset release, saturating, so the synchroniser can fill
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      settle_ff <= cmpirq_pkg::BIT2_RST;
      rd_data_ff <= 1'b0;
    end else begin
      if (settle_ff != cmpirq_pkg::SETTLE_MAX) begin
        settle_ff <= settle_ff + 2'h1;
      end
      if (ar_hs) begin
        rd_data_ff <= rd_is_data;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_clear0;
    clear_req[0] && armed[0];
  endsequence

  sequence s_clear1;
    clear_req[1] && armed[1];
  endsequence

  sequence s_arm0;
    data_read && ctrl_ff[0].on && ctrl_ff[0].irq_on;
  endsequence

  rsvd_zero_a: assert property ( // [R1]
    rvalid_ff && rd_data_ff |-> rdata_ff[7:6] == 2'h0 && rdata_ff[3:2] == 2'h0
  ) else $error("reserved data bits read non-zero");

  flag1_set_a: assert property ( // [R2]
    chan_event[1] |=> flag[1]
  ) else $error("channel 1 event did not set its flag");

  flag1_clear_a: assert property ( // [R3]
    $fell(flag[1]) |-> $past(clear_req[1] && armed[1])
  ) else $error("channel 1 flag fell without read-then-clear");

  flag1_clr_ok_a: assert property ( // [R3]
    s_clear1 ##0 !chan_event[1] |=> !flag[1]
  ) else $error("channel 1 flag survived a valid clear");

  flag0_set_a: assert property ( // [R4]
    chan_event[0] |=> flag[0]
  ) else $error("channel 0 event did not set its flag");

  flag0_clear_a: assert property ( // [R5]
    $fell(flag[0]) |-> $past(clear_req[0] && armed[0])
  ) else $error("channel 0 flag fell without read-then-clear");

  flag0_clr_ok_a: assert property ( // [R5]
    s_clear0 ##0 !chan_event[0] |=> !flag[0]
  ) else $error("channel 0 flag survived a valid clear");

  one_write_a: assert property ( // [R6]
    wr_fire && wr_is_data && wdata_ff[5:4] == 2'h3 && chan_event == 2'h0
    |=> flag == $past(flag)
  ) else $error("writing ones changed a flag");

  result1_read_a: assert property ( // [R7]
    data_read |=> s_axi_rdata[1] == $past(result_sync[1])
  ) else $error("channel 1 result bit misread");

  result0_read_a: assert property ( // [R8]
    data_read |=> s_axi_rdata[0] == $past(result_sync[0])
  ) else $error("channel 0 result bit misread");

  result_live_a: assert property ( // [R9] [R22]
    settle_ff == cmpirq_pkg::SETTLE_MAX |-> result_sync == $past(cmp_out_async, 2)
  ) else $error("result does not follow comparator two cycles later");

  latch_arm_a: assert property ( // [R10]
    s_arm0 |=> int_en[0] && latch[0] == $past(result_sync[0])
  ) else $error("armed read did not latch and enable channel 0");

  irq_raise_a: assert property ( // [R11]
    int_en[1] && result_sync[1] != latch[1] && !data_read |=> flag[1]
  ) else $error("mismatch did not raise channel 1 flag");

  read_mask_a: assert property ( // [R12]
    data_read |-> chan_event == 2'h0
  ) else $error("event raised while result read");

  read_refresh_a: assert property ( // [R13]
    data_read |=> latch == $past(result_sync)
  ) else $error("data read did not refresh latches");

  // the control bit lands one edge after the write, the internal enable one edge later
  irqen_drop_a: assert property ( // [R14]
    wr_ctrl[0] && !wdata_ff[cmpirq_pkg::CTRL_IRQ_BIT] |=> ##1 !int_en[0] && !chan_event[0]
  ) else $error("clearing irq enable left channel 0 armed");

  pin_claim_a: assert property ( // [R19]
    wr_ctrl[1] && wdata_ff[cmpirq_pkg::CTRL_ON_BIT] |=> pin_dedicated[1]
  ) else $error("enabled channel 1 did not claim its pin");

  ctrl_write_a: assert property ( // [R20]
    wr_ctrl[0] |=> chan_control[0] == $past(wdata_ff[7:0])
  ) else $error("control write not stored");

  bresp_hold_a: assert property (
    bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff)
  ) else $error("write response dropped before taken");

endmodule

// file: verif/cmpirq_analog_model.sv
// Purpose: behavioural model of the two analog comparators
// Assumes: voltages are codes, a larger code is a higher voltage
// Notes: outputs lag their inputs by a fraction of a cycle, unrelated to clk_sys
`timescale 1ns/10ps
module cmpirq_analog_model (
  // voltages at the two inputs and the shared reference
  input wire logic [1:0][7:0] vin,
  input wire logic [7:0] vref,
  // raw comparator outputs
  output logic [1:0] cmp_out_async
);
  ////////////////////////////////////////////////////////////////////////////
  // strict greater-than: equal voltages give 0, so the boundary is exercised
  initial cmp_out_async = 2'h0;
  always @(vin or vref) begin
    cmp_out_async[0] <= #3.7 (vin[0] > vref);
    cmp_out_async[1] <= #3.7 (vin[1] > vref);
  end
endmodule

// file: verif/comparator_result_irq_tb_top.sv
// Purpose: self-checking bench for the comparator result and flag block
// Assumes: an AXI4-Lite master driven by NBA right after rising edges
// Notes: waits of six cycles cover model lag, synchroniser and flag set
`timescale 1ns/10ps
module comparator_result_irq_tb_top;
  logic clk_sys, reset_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, vref;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmp_out_async, pin_dedicated, chan_irq_flag, rsp;
  cmpirq_pkg::cmpirq_ctrl_type [1:0] chan_control;
  logic [1:0][7:0] vin;
  int err_total, n_checks;

  ////////////////////////////////////////////////////////////////////////////
  cmpirq_top dut_u (.clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .cmp_out_async, .chan_control, .pin_dedicated, .chan_irq_flag);
  cmpirq_analog_model model_u (.vin, .vref, .cmp_out_async);

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // aw and w offered together, each released when taken, bready held up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left, w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (aw_left && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end while (aw_left || w_left);
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // read and compare, answer must be OKAY
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a, rd, rsp);
    chk("read data", rd, exp);
    chk("read resp", 32'(rsp), 32'(cmpirq_pkg::RESP_OKAY));
  endtask

  task automatic settle;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1;
    vin = 16'h0000;
    vref = 8'h80;
    err_total = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rchk(cmpirq_pkg::CTRL_OFS[0], 32'h0000_0000);
    rchk(cmpirq_pkg::CTRL_OFS[1], 32'h0000_0000);
    rchk(cmpirq_pkg::DATA_OFS, 32'h0000_0000);
    $display("test reset done");
    // result bits against the reference, equality on channel 0 must read 0
    for (int k = 0; k < 4; k++) begin
      vin[0] <= k[0] ? 8'h81 : 8'h80;
      vin[1] <= k[1] ? 8'h81 : 8'h7f;
      settle();
      rchk(cmpirq_pkg::DATA_OFS, 32'(k));
    end
    // ones into every bit: reserved stay 0 and flags are not set
    wr(cmpirq_pkg::DATA_OFS, 32'h0000_00ff, rsp);
    rchk(cmpirq_pkg::DATA_OFS, 32'h0000_0003);
    $display("test results done");
    // control registers; no write pairs external reference with hysteresis
    wr(cmpirq_pkg::CTRL_OFS[0], 32'h0000_00a5, rsp);
    wr(cmpirq_pkg::CTRL_OFS[1], 32'h0000_005a, rsp);
    rchk(cmpirq_pkg::CTRL_OFS[0], 32'h0000_00a5);
    rchk(cmpirq_pkg::CTRL_OFS[1], 32'h0000_005a);
    chk("control pins", 32'(chan_control), 32'h0000_5aa5);
    chk("pin dedicated", 32'(pin_dedicated), 32'h0000_0001);
    // a write with byte lane 0 masked must leave the register alone but still answer OKAY
    s_axi_wstrb <= 4'h0;
    wr(cmpirq_pkg::CTRL_OFS[0], 32'h0000_0000, rsp);
    s_axi_wstrb <= 4'h1;
    chk("masked write resp", 32'(rsp), 32'(cmpirq_pkg::RESP_OKAY));
    rchk(cmpirq_pkg::CTRL_OFS[0], 32'h0000_00a5);
    wr(cmpirq_pkg::CTRL_OFS[0], 32'h0000_0000, rsp);
    wr(cmpirq_pkg::CTRL_OFS[1], 32'h0000_0000, rsp);
    // unmapped place answers with an error
    wr(8'h0c, 32'h0000_00ff, rsp);
    chk("unmapped write resp", 32'(rsp), 32'(cmpirq_pkg::RESP_SLVERR));
    rd_reg(8'h0c, rd, rsp);
    chk("unmapped read resp", 32'(rsp), 32'(cmpirq_pkg::RESP_SLVERR));
    chk("unmapped read data", rd, 32'h0000_0000);
    $display("test control done");
    // per channel: arm, event, refused and accepted clears, disarm
    for (int ch = 0; ch < 2; ch++) begin
      vin <= 16'h7070;
      settle();
      wr(cmpirq_pkg::CTRL_OFS[ch], 32'h0000_0080, rsp);
      settle();
      rd_reg(cmpirq_pkg::DATA_OFS, rd, rsp);
      vin[ch] <= 8'h90;
      settle();
      chk("flag without irq enable", 32'(chan_irq_flag), 32'h0000_0000);
      wr(cmpirq_pkg::CTRL_OFS[ch], 32'h0000_00c0, rsp);
      rd_reg(cmpirq_pkg::DATA_OFS, rd, rsp);
      settle();
      chk("flag while result equals latch", 32'(chan_irq_flag), 32'h0000_0000);
      vin[ch] <= 8'h70;
      settle();
      chk("flag after change", 32'(chan_irq_flag), 32'(1 << ch));
      wr(cmpirq_pkg::DATA_OFS, 32'h0000_0000, rsp);
      chk("flag after unread clear", 32'(chan_irq_flag), 32'(1 << ch));
      rchk(cmpirq_pkg::DATA_OFS, 32'(1 << (cmpirq_pkg::FLAG_LSB + ch)));
      wr(cmpirq_pkg::DATA_OFS, 32'h0000_0030, rsp);
      chk("flag after one write", 32'(chan_irq_flag), 32'(1 << ch));
      rd_reg(cmpirq_pkg::DATA_OFS, rd, rsp);
      wr(cmpirq_pkg::DATA_OFS, 32'h0000_0000, rsp);
      settle();
      chk("flag after clear", 32'(chan_irq_flag), 32'h0000_0000);
      vin[ch] <= 8'h90;
      settle();
      chk("flag stays armed", 32'(chan_irq_flag), 32'(1 << ch));
      rd_reg(cmpirq_pkg::DATA_OFS, rd, rsp);
      wr(cmpirq_pkg::DATA_OFS, 32'h0000_0000, rsp);
      wr(cmpirq_pkg::CTRL_OFS[ch], 32'h0000_0080, rsp);
      vin[ch] <= 8'h70;
      settle();
      chk("flag after irq disable", 32'(chan_irq_flag), 32'h0000_0000);
      wr(cmpirq_pkg::CTRL_OFS[ch], 32'h0000_0000, rsp);
      $display("test interrupt channel %0d done", ch);
    end
    end_sim();
  end
endmodule
